// [masd_pkg.sv]
// masd_pkg: constants and carrier types for the address-space decoder
// assumes: a single 8-bit core on clk_sys issuing one access per cycle
package masd_pkg;

  // register file space
  localparam int unsigned REG_SPACE_BYTES = 4096;         // whole register file
  localparam logic [11:0] CTRL_BASE       = 12'hf00;      // control window start
  localparam logic [11:0] CTRL_LAST       = 12'hfff;      // control window end
  localparam logic [11:0] RAM_BASE        = 12'h000;      // ram start
  localparam int unsigned RAM_MIN_BYTES   = 256;          // smallest ram variant
  localparam int unsigned RAM_MAX_BYTES   = 1024;         // largest ram variant

  // program space
  localparam int unsigned PROG_SPACE_BYTES = 65536;       // 64 KB program space
  localparam int unsigned FLASH_MIN_BYTES  = 1024;        // smallest flash variant
  localparam int unsigned FLASH_MAX_BYTES  = 8192;        // largest flash variant
  localparam logic [7:0]  ERASED_BYTE      = 8'hff;       // unimplemented reads

  // low program space vector layout
  localparam logic [15:0] OPTION_BITS_ADDR   = 16'h0000;  // two option bytes
  localparam logic [15:0] RESET_VEC_ADDR     = 16'h0002;  // reset vector
  localparam logic [15:0] WATCHDOG_VEC_ADDR  = 16'h0004;  // watchdog_vector_slot
  localparam logic [15:0] ILLEGAL_TRAP_ADDR  = 16'h0006;  // illegal instruction trap
  localparam logic [15:0] IRQ_VEC_FIRST      = 16'h0008;  // interrupt vectors start
  localparam logic [15:0] IRQ_VEC_LAST       = 16'h0037;  // interrupt vectors end
  localparam logic [15:0] VEC_RSVD_ADDR      = 16'h0038;  // reserved pair
  localparam logic [15:0] OSC_FAIL_FIRST     = 16'h003a;  // oscillator fail vectors
  localparam logic [15:0] OSC_FAIL_LAST      = 16'h003d;
  localparam logic [15:0] CODE_START_ADDR    = 16'h003e;  // ordinary code

  // information area overlay
  localparam int unsigned INFO_BYTES       = 128;         // info area size
  localparam logic [15:0] INFO_FIRST       = 16'hfe00;    // overlay start
  localparam logic [15:0] INFO_LAST        = 16'hff7f;    // overlay end
  localparam int unsigned INFO_EN_BIT      = 7;           // page select enable bit
  localparam logic [6:0]  INFO_PARTID_LO   = 7'h40;       // part id start
  localparam logic [6:0]  INFO_PARTID_HI   = 7'h53;       // part id end
  localparam logic [6:0]  INFO_RSVD_LO     = 7'h54;       // reserved start
  localparam logic [6:0]  INFO_RSVD_HI     = 7'h5f;       // reserved end
  localparam logic [7:0]  PAGE_SEL_RESET   = 8'h00;       // page select after reset

  // access space selector
  typedef enum logic [1:0] {
    MASD_SP_REG,
    MASD_SP_PROG,
    MASD_SP_DATA
  } masd_space_t;

  // one core request
  typedef struct packed {
    logic        valid;
    logic        write;
    masd_space_t space;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } masd_req_t;

  // decoded class of a request
  typedef enum logic [2:0] {
    MASD_HIT_RAM,
    MASD_HIT_CTRL,
    MASD_HIT_REG_HOLE,
    MASD_HIT_FLASH,
    MASD_HIT_PROG_HOLE,
    MASD_HIT_INFO,
    MASD_HIT_NONE
  } masd_hit_t;

  // answer to the core
  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
    masd_hit_t   hit;
  } masd_rsp_t;

endpackage : masd_pkg

// [masd_byte_mem.sv]
// masd_byte_mem: byte-wide synchronous memory with registered read data
// assumes: one read or write per cycle; a read with a write returns the old byte
`timescale 1ns/1ps
`default_nettype none
module masd_byte_mem
  import masd_pkg::*;
#(
  parameter int unsigned DEPTH = 256,             // bytes held
  parameter int unsigned AW    = $clog2(DEPTH)    // address width
) (
  input  wire logic          clk_sys,
  input  wire logic          wrEn,
  input  wire logic          rdEn,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata_reg
);

  logic [7:0] store [DEPTH];                      // storage array

  // write port
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      store[addr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk_sys) begin
    if (rdEn) begin
      rdata_reg <= store[addr];
    end
  end

endmodule // masd_byte_mem
`default_nettype wire

// [masd_info_rom.sv]
// masd_info_rom: read-only 128-byte information area, registered output
// assumes: contents fixed at build time through parameters
`timescale 1ns/1ps
`default_nettype none
module masd_info_rom
  import masd_pkg::*;
#(
  parameter logic [159:0] PART_ID  = {20{8'hff}}, // part id text, first char in msb
  parameter logic [7:0]   CAL_FILL = 8'h00        // factory option/calibration fill
) (
  input  wire logic       clk_sys,
  input  wire logic       rdEn,
  input  wire logic [6:0] addr,
  output logic      [7:0] rdata_reg
);

  logic [7:0] romByte;                            // combinational lookup
  logic [4:0] idIdx;                              // part id character index

  // fixed contents: option/cal data, part id, reserved
  always_comb begin
    idIdx   = 5'(addr - INFO_PARTID_LO);
    romByte = CAL_FILL;                            // see RULE16
    if (addr >= INFO_PARTID_LO && addr <= INFO_PARTID_HI) begin
      romByte = PART_ID[8'(159 - 8 * idIdx) -: 8]; // see RULE15
    end else if (addr >= INFO_RSVD_LO && addr <= INFO_RSVD_HI) begin
      romByte = ERASED_BYTE;                       // reserved reads as erased
    end
  end

  // registered read, no write path exists
  always_ff @(posedge clk_sys) begin
    if (rdEn) begin
      rdata_reg <= romByte;                        // see RULE14
    end
  end

endmodule // masd_info_rom
`default_nettype wire

// [mcu_address_space_decode.sv]
// mcu_address_space_decode: decodes core accesses to register and program spaces
// assumes: core issues at most one request per cycle, answer one cycle later;
// control registers live outside and are reached through the ctrl strobes
//
// How it works
// RULE1 - register file spans 4096 byte addresses
// RULE2 - F00H-FFFH go to control registers
// RULE3 - unassigned control reads return undefined data
// RULE4 - core should not write unassigned control addresses
// RULE5 - ram starts at 000H, contiguous upward
// RULE6 - ram size parameter, 256 to 1024
// RULE7 - gap above ram: undefined reads, ignored writes
// RULE8 - 64 KB program space, 1-8 KB flash
// RULE9 - beyond flash reads FFH, writes ignored
// RULE10 - fixed vector layout at program bottom
// RULE11 - data memory space decodes nothing
// RULE12 - info area enabled by page bit 7
// RULE13 - enabled overlay returns info at FE00H-FF7FH
// RULE14 - info area is read-only
// RULE15 - part id at FE40-FE53, FFH padded
// RULE16 - option/calibration data, FE54-FE5F reserved
// RULE17 - reset clears information area enable
`timescale 1ns/1ps
`default_nettype none
module mcu_address_space_decode
  import masd_pkg::*;
#(
  parameter int unsigned RAM_BYTES   = RAM_MAX_BYTES,    // see RULE6
  parameter int unsigned FLASH_BYTES = FLASH_MAX_BYTES,  // see RULE8
  parameter logic [159:0] PART_ID    = {20{8'hff}},      // arbitrary part id text
  parameter logic [7:0]   CAL_FILL   = 8'h00             // arbitrary calibration fill
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire masd_req_t  coreReq,        // request from the core
  output masd_rsp_t       coreRsp,        // answer one cycle later
  input  wire logic       pageSelWr,      // page select register write strobe
  input  wire logic [7:0] pageSelData,    // page select write data
  output logic      [7:0] pageSel_reg,    // current page select value
  output logic            ctrlWr,         // control window write strobe
  output logic            ctrlRd,         // control window read strobe
  output logic      [7:0] ctrlAddr_reg,   // control register offset
  output logic      [7:0] ctrlWdata_reg,  // control write data
  input  wire logic [7:0] ctrlRdata,      // control read data, valid with answer
  output logic            flashWr,        // write to implemented flash
  output logic     [15:0] flashWaddr_reg, // flash write address
  output logic      [7:0] flashWdata_reg  // flash write data
);

  localparam int unsigned RAM_AW   = $clog2(RAM_BYTES);   // ram address width
  localparam int unsigned FLASH_AW = $clog2(FLASH_BYTES); // flash address width

  masd_hit_t  hitNow;                 // class of the current request
  masd_hit_t  hit_reg;                // class of the request being answered
  logic       valid_reg;              // answer pending
  logic       infoEn;                 // overlay enable
  logic       ramWr;                  // ram write strobe
  logic       ramRd;                  // ram read strobe
  logic       flashRd;                // flash read strobe
  logic       infoRd;                 // info read strobe
  logic [7:0] ramRdata;               // ram read data
  logic [7:0] flashRdata;             // flash read data
  logic [7:0] infoRdata;              // info read data
  logic [7:0] ctrlAddr_next;          // next control offset
  logic       ctrlWr_reg;             // registered control write strobe
  logic       ctrlRd_reg;             // registered control read strobe
  logic       flashWr_reg;            // registered flash write strobe
  logic       flashWrNow;             // flash write in the request cycle

  // address map at a glance
  //
  // register space, low 12 address bits only:
  //   000 up to RAM_BYTES-1     general purpose ram
  //   RAM_BYTES up to eff       hole, reads undefined, writes dropped
  //   f00 up to fff             control window, forwarded as strobes
  //
  // program space, all 16 address bits:
  //   0000 up to FLASH_BYTES-1  flash image, vectors at the bottom
  //   FLASH_BYTES up to ffff    hole, reads all ones, writes dropped
  //   fe00 up to ff7f           info overlay when page bit 7 is set
  //
  // data space:
  //   nothing decoded, every access is answered with class none
  //
  // timing:
  //   a request is taken on the edge where coreReq.valid is high
  //   the answer stands in the cycle after that edge, for one cycle
  //   read data comes from the memories' output registers, or from
  //   the control block's read data input for the control window
  //   requests may follow each other on every edge, nothing stalls
  //
  // writes:
  //   ram and flash are written on the edge that takes the request
  //   control and flash strobes leave the block one cycle later
  //   the overlay never takes writes; they fall to normal decode
  //
  // hazards a user must know:
  //   control reads return whatever the control block drives; an
  //   unassigned offset gives that block's own undefined value
  //   writes to unassigned control offsets are passed on unchanged
  //   the hole answers are constants, not a copy of any storage
  //   the page select register is written straight from a port
  //   the overlay enable drops on reset, so the first fetches after
  //   reset always see plain program decode at fe00 to ff7f
  //
  // trade-offs:
  //   the flash image is an ordinary byte memory; programming and
  //   erase timing belong to a block outside this one
  //   the info area is a fixed table built from two parameters, so
  //   no storage is spent on it and no write path can reach it
  //   decode is purely combinational ahead of the memory registers,
  //   which keeps the answer latency at exactly one cycle

  assign infoEn = pageSel_reg[INFO_EN_BIT];                  // see RULE12

  // classify the request by space and address
  always_comb begin
    hitNow = MASD_HIT_NONE;
    if (coreReq.valid) begin
      case (coreReq.space)
        MASD_SP_REG: begin
          if (coreReq.addr[11:0] >= CTRL_BASE) begin
            hitNow = MASD_HIT_CTRL;                          // see RULE2
          end else if (32'(coreReq.addr[11:0] - RAM_BASE) < RAM_BYTES) begin
            hitNow = MASD_HIT_RAM;                           // see RULE5
          end else begin
            hitNow = MASD_HIT_REG_HOLE;                      // see RULE7
          end
        end
        MASD_SP_PROG: begin
          if (infoEn && !coreReq.write && coreReq.addr >= INFO_FIRST
              && coreReq.addr <= INFO_LAST) begin
            hitNow = MASD_HIT_INFO;                          // see RULE13
          end else if (32'(coreReq.addr) < FLASH_BYTES) begin
            hitNow = MASD_HIT_FLASH;                         // see RULE8
          end else begin
            hitNow = MASD_HIT_PROG_HOLE;                     // see RULE9
          end
        end
        MASD_SP_DATA: begin
          hitNow = MASD_HIT_NONE;                            // see RULE11
        end
        default: begin
          hitNow = MASD_HIT_NONE;
        end
      endcase
    end
  end

  // strobes per target; register file uses only the low 12 bits, see RULE1
  assign ramWr   = (hitNow == MASD_HIT_RAM) && coreReq.write;
  assign ramRd   = (hitNow == MASD_HIT_RAM) && !coreReq.write;
  assign flashRd = (hitNow == MASD_HIT_FLASH) && !coreReq.write;
  assign flashWrNow = (hitNow == MASD_HIT_FLASH) && coreReq.write; // see RULE9
  assign infoRd  = (hitNow == MASD_HIT_INFO);                // see RULE14
  assign ctrlAddr_next = coreReq.addr[7:0];

  // general purpose ram from address zero
  masd_byte_mem #(
    .DEPTH (RAM_BYTES),
    .AW    (RAM_AW)
  ) u_ram (
    .clk_sys   (clk_sys),
    .wrEn      (ramWr),
    .rdEn      (ramRd),
    .addr      (coreReq.addr[RAM_AW-1:0]),
    .wdata     (coreReq.wdata),
    .rdata_reg (ramRdata)
  );

  // flash read image; written in the request cycle like the ram, so a read
  // issued right after a write never loses its address to a late write
  masd_byte_mem #(
    .DEPTH (FLASH_BYTES),
    .AW    (FLASH_AW)
  ) u_flash (
    .clk_sys   (clk_sys),
    .wrEn      (flashWrNow),
    .rdEn      (flashRd),
    .addr      (coreReq.addr[FLASH_AW-1:0]),
    .wdata     (coreReq.wdata),
    .rdata_reg (flashRdata)
  );

  // information area, no write port at all
  masd_info_rom #(
    .PART_ID  (PART_ID),
    .CAL_FILL (CAL_FILL)
  ) u_info (
    .clk_sys   (clk_sys),
    .rdEn      (infoRd),
    .addr      (coreReq.addr[6:0]),
    .rdata_reg (infoRdata)
  );

  // page select register, overlay off after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pageSel_reg <= PAGE_SEL_RESET;                         // see RULE17
    end else if (pageSelWr) begin
      pageSel_reg <= pageSelData;                            // see RULE12
    end
  end

  // answer tracking
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      valid_reg <= 1'b0;
      hit_reg   <= MASD_HIT_NONE;
    end else begin
      valid_reg <= coreReq.valid;
      hit_reg   <= hitNow;
    end
  end

  // control window strobes, forwarded as is; writes to unassigned offsets
  // are passed on too, the core is trusted not to make them, see RULE4
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrlWr_reg    <= 1'b0;
      ctrlRd_reg    <= 1'b0;
      ctrlAddr_reg  <= 8'h00;
      ctrlWdata_reg <= 8'h00;
    end else begin
      ctrlWr_reg    <= (hitNow == MASD_HIT_CTRL) && coreReq.write; // see RULE2
      ctrlRd_reg    <= (hitNow == MASD_HIT_CTRL) && !coreReq.write;
      ctrlAddr_reg  <= ctrlAddr_next;
      ctrlWdata_reg <= coreReq.wdata;
    end
  end

  // flash write path only for implemented locations, vectors included
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flashWr_reg    <= 1'b0;
      flashWaddr_reg <= 16'h0000;
      flashWdata_reg <= 8'h00;
    end else begin
      flashWr_reg    <= flashWrNow;                          // see RULE9
      flashWaddr_reg <= coreReq.addr;                        // see RULE10
      flashWdata_reg <= coreReq.wdata;
    end
  end

  assign ctrlWr  = ctrlWr_reg;
  assign ctrlRd  = ctrlRd_reg;
  assign flashWr = flashWr_reg;

  // read data mux for the answer cycle
  always_comb begin
    coreRsp.valid = valid_reg;
    coreRsp.hit   = hit_reg;
    case (hit_reg)
      MASD_HIT_RAM:       coreRsp.rdata = ramRdata;
      MASD_HIT_CTRL:      coreRsp.rdata = ctrlRdata;         // see RULE3
      MASD_HIT_FLASH:     coreRsp.rdata = flashRdata;
      MASD_HIT_INFO:      coreRsp.rdata = infoRdata;         // see RULE13
      MASD_HIT_PROG_HOLE: coreRsp.rdata = ERASED_BYTE;       // see RULE9
      MASD_HIT_REG_HOLE:  coreRsp.rdata = 8'h00;             // undefined, see RULE7
      default:            coreRsp.rdata = 8'h00;             // see RULE11
    endcase
  end

endmodule // mcu_address_space_decode
`default_nettype wire

// [masd_checker.sv]
// masd_checker: port assertions for the address-space decoder
// assumes: bound into mcu_address_space_decode, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module masd_checker
  import masd_pkg::*;
#(
  parameter int unsigned RAM_BYTES   = 256,  // implemented ram
  parameter int unsigned FLASH_BYTES = 1024  // implemented flash
) (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire masd_req_t   coreReq,
  input wire masd_rsp_t   coreRsp,
  input wire logic [7:0]  pageSel_reg,
  input wire logic        ctrlWr,
  input wire logic        ctrlRd,
  input wire logic [7:0]  ctrlAddr_reg,
  input wire logic [7:0]  ctrlRdata,
  input wire logic        flashWr,
  input wire logic [15:0] flashWaddr_reg
);
  logic        rq;  // request taken this edge
  logic        wq;  // write request
  logic        rs;  // register space
  logic        ps;  // program space
  logic        ov;  // overlay hit
  logic [11:0] ra;  // register offset
  logic [15:0] pa;  // program address
  assign rq = coreReq.valid;
  assign wq = coreReq.valid & coreReq.write;
  assign rs = coreReq.space == MASD_SP_REG;
  assign ps = coreReq.space == MASD_SP_PROG;
  assign ra = coreReq.addr[11:0];
  assign pa = coreReq.addr;
  assign ov = pageSel_reg[7] & (pa >= INFO_FIRST) & (pa <= INFO_LAST);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_answer_one_cycle: assert property (rq |=> coreRsp.valid)
    else $error("no answer after request");
  chk_ctrl_read_strobe: assert property (rq && !wq && rs && ra >= CTRL_BASE
    |=> ctrlRd && ctrlAddr_reg == $past(coreReq.addr[7:0])) else $error("ctrl read decode");
  chk_ctrl_data_path: assert property (ctrlRd |-> coreRsp.rdata == ctrlRdata
    && coreRsp.hit == MASD_HIT_CTRL) else $error("ctrl read data");
  chk_reg_hole_quiet: assert property (wq && rs && ra >= RAM_BYTES && ra < CTRL_BASE
    |=> !ctrlWr && !flashWr && coreRsp.hit == MASD_HIT_REG_HOLE) else $error("reg hole write");
  chk_flash_write_path: assert property (wq && ps && pa < FLASH_BYTES
    |=> flashWr && flashWaddr_reg == $past(coreReq.addr)) else $error("flash write");
  chk_prog_hole_ff: assert property (rq && ps && pa >= FLASH_BYTES && !ov |=> !flashWr
    && (coreRsp.rdata == ERASED_BYTE || $past(coreReq.write))) else $error("prog hole");
  chk_info_overlay_hit: assert property (rq && !wq && ps && ov
    |=> coreRsp.hit == MASD_HIT_INFO) else $error("overlay miss");
  chk_data_space_none: assert property (rq && coreReq.space == MASD_SP_DATA
    |=> coreRsp.hit == MASD_HIT_NONE && !ctrlWr && !flashWr) else $error("data space");
  chk_page_after_reset: assert property ($fell(reset) |-> pageSel_reg == PAGE_SEL_RESET)
    else $error("page select not cleared");
endmodule // masd_checker
bind mcu_address_space_decode masd_checker #(.RAM_BYTES(RAM_BYTES), .FLASH_BYTES(FLASH_BYTES)) u_chk (
  .clk_sys, .reset, .coreReq, .coreRsp, .pageSel_reg, .ctrlWr, .ctrlRd, .ctrlAddr_reg,
  .ctrlRdata, .flashWr, .flashWaddr_reg);
`default_nettype wire

// [masd_ctrl_model.sv]
// masd_ctrl_model: stand-in for the control registers behind the window
// assumes: read data wanted in the cycle ctrlRd is high
`timescale 1ns/1ps
`default_nettype none
module masd_ctrl_model
  import masd_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       ctrlRd,
  input  wire logic [7:0] ctrlAddr_reg,
  output logic      [7:0] ctrlRdata
);
  logic [7:0] churn_reg = 8'h00;  // filler, never stale
  // filler moves every cycle so old data never passes for new
  always_ff @(posedge clk_sys) begin
    churn_reg <= churn_reg + 8'h3b;
  end
  // answer offset xor a5 only while selected
  assign ctrlRdata = ctrlRd ? (ctrlAddr_reg ^ 8'ha5) : churn_reg;
endmodule // masd_ctrl_model
`default_nettype wire

// [mcu_address_space_decode_tb_top.sv]
// mcu_address_space_decode_tb_top: directed checks of the decoder
// assumes: 25 MHz clock, answer one cycle after each request
`timescale 1ns/1ps
`default_nettype none
module mcu_address_space_decode_tb_top
  import masd_pkg::*;
;
  logic        clk_sys, reset, pageSelWr, ctrlWr, ctrlRd, flashWr;
  logic [7:0]  pageSelData, pageSel_reg, ctrlAddr_reg, ctrlWdata_reg, ctrlRdata, flashWdata_reg;
  logic [15:0] flashWaddr_reg;
  masd_req_t   coreReq;
  masd_rsp_t   coreRsp;
  int          err_total, samples_checked;
  mcu_address_space_decode #(.RAM_BYTES(256), .FLASH_BYTES(1024),
    .PART_ID({8'h41, 8'h42, {18{8'hff}}}), .CAL_FILL(8'h5a)) u_dut (
    .clk_sys, .reset, .coreReq, .coreRsp, .pageSelWr, .pageSelData, .pageSel_reg, .ctrlWr,
    .ctrlRd, .ctrlAddr_reg, .ctrlWdata_reg, .ctrlRdata, .flashWr, .flashWaddr_reg, .flashWdata_reg);
  masd_ctrl_model u_ctrl (.clk_sys, .ctrlRd, .ctrlAddr_reg, .ctrlRdata);
  // 40 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // one comparison, counted
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one core access; returns in the answer cycle
  task automatic acc(logic w, masd_space_t sp, logic [15:0] a, logic [7:0] d);
    @(posedge clk_sys);
    coreReq <= '{1'b1, w, sp, a, d};
    @(posedge clk_sys);
    coreReq.valid <= 1'b0;
    #1;
  endtask
  // read and judge data and class
  task automatic rd(masd_space_t sp, logic [15:0] a, logic [7:0] e, masd_hit_t h);
    acc(1'b0, sp, a, 8'h00);
    chk("rdata", e, coreRsp.rdata);
    chk("hit", h, coreRsp.hit);
  endtask
  // page select write pulse
  task automatic page(logic [7:0] v);
    @(posedge clk_sys);
    pageSelWr   <= 1'b1;
    pageSelData <= v;
    @(posedge clk_sys);
    pageSelWr <= 1'b0;
    #1;
    chk("pageSel", v, pageSel_reg);
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk("pageSel", 16'h0000, pageSel_reg);
    chk("rspValid", 16'h0000, coreRsp.valid);
  endtask
  // ram at the bottom, gap above it is inert
  task automatic t_reg();
    acc(1'b1, MASD_SP_REG, 16'h0000, 8'h3c);
    acc(1'b1, MASD_SP_REG, 16'h00ff, 8'hc3);
    acc(1'b1, MASD_SP_REG, 16'h0100, 8'h77);
    chk("ctrlWr", 16'h0000, ctrlWr);
    rd(MASD_SP_REG, 16'h0000, 8'h3c, MASD_HIT_RAM);
    rd(MASD_SP_REG, 16'h00ff, 8'hc3, MASD_HIT_RAM);
    rd(MASD_SP_REG, 16'h0100, 8'h00, MASD_HIT_REG_HOLE);
    rd(MASD_SP_DATA, 16'h0010, 8'h00, MASD_HIT_NONE);
  endtask
  // control window strobes, assigned offsets only
  task automatic t_ctrl();
    rd(MASD_SP_REG, 16'h0f41, 8'he4, MASD_HIT_CTRL);
    chk("ctrlAddr", 16'h0041, ctrlAddr_reg);
    acc(1'b1, MASD_SP_REG, 16'h0f86, 8'h12);
    chk("ctrlWr", 16'h0001, ctrlWr);
    chk("ctrlWdata", 16'h0012, ctrlWdata_reg);
  endtask
  // flash edges and the region beyond it
  task automatic t_flash();
    acc(1'b1, MASD_SP_PROG, RESET_VEC_ADDR, 8'ha1);
    chk("flashWaddr", RESET_VEC_ADDR, flashWaddr_reg);
    chk("flashWdata", 16'h00a1, flashWdata_reg);
    acc(1'b1, MASD_SP_PROG, 16'h03ff, 8'h5e);
    rd(MASD_SP_PROG, RESET_VEC_ADDR, 8'ha1, MASD_HIT_FLASH);
    rd(MASD_SP_PROG, 16'h03ff, 8'h5e, MASD_HIT_FLASH);
    acc(1'b1, MASD_SP_PROG, 16'h0400, 8'h11);
    chk("flashWr", 16'h0000, flashWr);
    rd(MASD_SP_PROG, 16'h0400, 8'hff, MASD_HIT_PROG_HOLE);
  endtask
  // information overlay, off, wrong bit, on, written
  task automatic t_info();
    rd(MASD_SP_PROG, 16'hfe40, 8'hff, MASD_HIT_PROG_HOLE);
    page(8'h7f);
    rd(MASD_SP_PROG, 16'hfe40, 8'hff, MASD_HIT_PROG_HOLE);
    page(8'h80);
    rd(MASD_SP_PROG, 16'hfe40, 8'h41, MASD_HIT_INFO);
    rd(MASD_SP_PROG, 16'hfe41, 8'h42, MASD_HIT_INFO);
    rd(MASD_SP_PROG, 16'hfe53, 8'hff, MASD_HIT_INFO);
    rd(MASD_SP_PROG, 16'hfe54, 8'hff, MASD_HIT_INFO);
    rd(MASD_SP_PROG, 16'hfe00, 8'h5a, MASD_HIT_INFO);
    rd(MASD_SP_PROG, 16'hfe7f, 8'h5a, MASD_HIT_INFO);
    acc(1'b1, MASD_SP_PROG, 16'hfe40, 8'h00);
    chk("flashWr", 16'h0000, flashWr);
    rd(MASD_SP_PROG, 16'hfe40, 8'h41, MASD_HIT_INFO);
    do_reset();
    rd(MASD_SP_PROG, 16'hfe40, 8'hff, MASD_HIT_PROG_HOLE);
  endtask
  // verdict and end of run
  task automatic conclude();
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    reset       = 1'b1;
    coreReq     = '0;
    pageSelWr   = 1'b0;
    pageSelData = 8'h00;
    do_reset();
    t_reg();
    t_ctrl();
    t_flash();
    t_info();
    conclude();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    conclude();
  end
endmodule // mcu_address_space_decode_tb_top
`default_nettype wire
